// File: design/fsi_indicator.sv
/*
  Status indication for a servo drive's fieldbus slave: port link/activity
  LEDs, physical link LEDs, run LED, fault code on a two-digit display,
  ring closure of an open output port and power-stage release gating.
  Assumes the PHY link and activity inputs and the enable pins are
  asynchronous; controller state and fault pulses are on mclk_i.
*/
// Summary of operation
// R1: Link/activity LED off, on, or blinking.
// R2: Compact variant PHY LED shows link only.
// R3: Run LED follows slave state pattern.
// R4: Watchdog expiry shows error 14 01.
// R5: Bad config memory shows error 14 02.
// R6: Internal RAM fault shows error 14 03.
// R7: Invalid network configuration shows 14 04.
// R8: Missing Sync Manager 2 data shows 14 05.
// R9: Local interface error shows 14 06.
// R10: Open output port loops transmit to receive.
// R11: Master feeds first slave's input port.
// R12: Without both enables, drive stays state 1/2.
// R13: Patterns come from programmable clock prescaler.
`timescale 1ns/1ns
module fsi_indicator
  import fsi_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC  // Default blink half period
) (
  input  wire logic             mclk_i,                  // System clock
  input  wire logic             rst_n_i,                 // Async reset, active low
  input  wire logic             compact_variant_i,       // Compact variant strap
  input  wire logic [PRE_W-1:0] prescale_i,              // Blink half period, 0 = default
  input  wire logic             in_link_i,               // Input port PHY link (pin)
  input  wire logic             in_act_i,                // Input port traffic (pin)
  input  wire logic             out_link_i,              // Output port PHY link (pin)
  input  wire logic             out_act_i,               // Output port traffic (pin)
  input  wire logic [1:0]       slave_state_i,           // Slave state, same clock
  input  wire logic [N_FAULT-1:0] fault_i,               // Fault pulses, same clock
  input  wire logic             fault_ack_i,             // Clear shown fault
  input  wire logic             power_stage_hw_enable_i, // Hardware enable pin
  input  wire logic             torque_off_release_input_i, // Torque-off release pin
  output logic                  in_la_led_o,             // Input port link/activity LED
  output logic                  out_la_led_o,            // Output port link/activity LED
  output logic                  in_phy_led_o,            // Input port PHY link LED
  output logic                  out_phy_led_o,           // Output port PHY link LED
  output logic                  run_state_indicator_o,   // Run LED
  output logic                  ring_loop_o,             // Output port looped back
  output logic                  power_release_o,         // Drive may leave states 1/2
  output logic                  fault_active_o,          // A fault code is shown
  output logic [7:0]            disp_o                   // Two BCD digits or code
);

  // Synchronised pin levels
  logic in_link, in_act, out_link, out_act, hw_en, torque_rel;
  logic [5:0] pins_raw;
  logic [5:0] pins_s;
  assign pins_raw = {in_link_i, in_act_i, out_link_i, out_act_i,
                     power_stage_hw_enable_i, torque_off_release_input_i};
  assign {in_link, in_act, out_link, out_act, hw_en, torque_rel} = pins_s;

  // One synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      fsi_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (pins_raw[g]),
        .level_o (pins_s[g])
      );
    end
  endgenerate

  // Prescaler and pattern counters
  logic [PRE_W-1:0] pre_cnt;     // Cycle count within half period
  logic [PRE_W-1:0] half_len;    // Selected half period
  logic             blink;       // Square wave
  logic [2:0]       flash_ph;    // Single-flash phase, 0 = lit
  logic             tick;        // End of half period

  // Zero selects the built-in default
  assign half_len = (prescale_i == '0) ? PRE_W'(BLINK_HALF) : prescale_i;
  assign tick     = (pre_cnt >= half_len - PRE_W'(1));

  // Half-period prescaler
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= '0; // R13
    end else begin
      pre_cnt <= pre_cnt + PRE_W'(1);
    end
  end

  // Blink and single-flash phase advance
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink    <= 1'b0;
      flash_ph <= 3'h0;
    end else if (tick) begin
      blink    <= ~blink; // R13
      flash_ph <= (flash_ph == 3'h5) ? 3'h0 : flash_ph + 3'h1;
    end
  end

  // Link/activity and PHY link LEDs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_la_led_o   <= 1'b0;
      out_la_led_o  <= 1'b0;
      in_phy_led_o  <= 1'b0;
      out_phy_led_o <= 1'b0;
    end else begin
      in_la_led_o   <= in_link & (in_act ? blink : 1'b1); // R1
      out_la_led_o  <= out_link & (out_act ? blink : 1'b1); // R1
      in_phy_led_o  <= compact_variant_i & in_link; // R2
      out_phy_led_o <= compact_variant_i & out_link; // R2
    end
  end

  // Run LED pattern from slave state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_state_indicator_o <= 1'b0;
    end else begin
      unique case (fsi_slave_state_t'(slave_state_i))
        FSI_ST_INIT:   run_state_indicator_o <= 1'b0; // R3
        FSI_ST_PREOP:  run_state_indicator_o <= blink; // R3
        FSI_ST_SAFEOP: run_state_indicator_o <= (flash_ph == 3'h0); // R3
        FSI_ST_OP:     run_state_indicator_o <= 1'b1; // R3
      endcase
    end
  end

  // Ring closure: loop when output port has no link; master sits upstream
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ring_loop_o <= 1'b1;
    end else begin
      ring_loop_o <= ~out_link; // R10 R11
    end
  end

  // Power stage release needs both enables
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_release_o <= 1'b0;
    end else begin
      power_release_o <= hw_en & torque_rel; // R12
    end
  end

  // Latched fault; lowest index wins when several arrive together
  logic [7:0] next_loc;
  logic       any_fault;
  always_comb begin
    next_loc = 8'h00;
    for (int i = N_FAULT - 1; i >= 0; i--) begin
      if (fault_i[i]) next_loc = 8'(i + 1); // R4 R5 R6 R7 R8 R9
    end
  end
  assign any_fault = |fault_i;

  logic [7:0] loc;  // Shown fault location
  // New fault wins over a simultaneous acknowledge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_active_o <= 1'b0;
      loc            <= 8'h00;
    end else if (any_fault) begin
      fault_active_o <= 1'b1;
      loc            <= next_loc; // R4 R5 R6 R7 R8 R9
    end else if (fault_ack_i) begin
      fault_active_o <= 1'b0;
    end
  end

  // Display sequence Er, group, location, blank
  fsi_phase_t phase;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= FSI_PH_ER;
    end else if (!fault_active_o || any_fault) begin
      phase <= FSI_PH_ER;
    end else if (tick && blink) begin
      phase <= fsi_phase_t'(phase + 2'h1);
    end
  end

  // Display data; 8'hee stands for "Er", 8'hff blank
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disp_o <= 8'hff;
    end else if (!fault_active_o) begin
      disp_o <= 8'hff;
    end else begin
      unique case (phase)
        FSI_PH_ER:  disp_o <= 8'hee;
        FSI_PH_GRP: disp_o <= ERR_GROUP; // R4
        FSI_PH_LOC: disp_o <= loc; // R4 R5 R6 R7 R8 R9
        FSI_PH_GAP: disp_o <= 8'hff;
      endcase
    end
  end

  // Run LED steady in operational state
  a_run_op_on: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
    slave_state_i == FSI_ST_OP |=> run_state_indicator_o)
    else $error("run LED not on in operational state");

  // Run LED dark in initialisation
  a_run_init_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
    slave_state_i == FSI_ST_INIT |=> !run_state_indicator_o)
    else $error("run LED lit in init state");

  // Link LED dark without link
  a_la_nolink: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    !in_link |=> !in_la_led_o)
    else $error("link LED lit without link");

  // Link LED steady with idle link
  a_la_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
    out_link && !out_act |=> out_la_led_o)
    else $error("link LED not steady on idle link");

  // PHY LED follows link on compact variant
  a_phy_link: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R2
    compact_variant_i |=> in_phy_led_o == $past(in_link))
    else $error("PHY LED does not follow link");

  // Loop is closed exactly while the output port lacks link
  a_ring_loop: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    ring_loop_o == !$past(out_link))
    else $error("ring not closed on open output");

  // Power stays blocked without both enables
  a_power_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
    !(hw_en && torque_rel) |=> !power_release_o)
    else $error("power released without both enables");

  // Watchdog fault shows location 01 on the next edge
  sequence s_wdog;
    fault_i == 6'h01;
  endsequence
  a_wdog_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
    s_wdog |=> fault_active_o && loc == LOC_WATCHDOG)
    else $error("watchdog fault code wrong");

  // Local error shows location 06
  a_local_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
    fault_i == 6'h20 |=> loc == LOC_LOCAL)
    else $error("local error code wrong");

  // Prescaler wraps within the half period; a shrunk period resettles in one cycle
  a_prescale: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
    $stable(half_len) |-> pre_cnt < half_len)
    else $error("prescaler ran past half period");

endmodule // fsi_indicator

// File: design/fsi_pkg.sv
/*
  Constants for the fieldbus status indicator: slave states, fault codes,
  display phases, drive states and blink timing.
  Assumes a 10 MHz system clock.
*/
package fsi_pkg;

  // System clock rate in Hz
  localparam int unsigned CLK_HZ       = 10_000_000;
  // Blink half period in ms
  localparam int unsigned BLINK_HALF_MS = 200;
  // Blink half period in clock cycles
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  // Prescaler width
  localparam int unsigned PRE_W        = 24;

  // Slave state codes, as reported by the communication controller
  typedef enum logic [1:0] {
    FSI_ST_INIT   = 2'h0,
    FSI_ST_PREOP  = 2'h1,
    FSI_ST_SAFEOP = 2'h2,
    FSI_ST_OP     = 2'h3
  } fsi_slave_state_t;

  // Error group for network faults
  localparam logic [7:0] ERR_GROUP    = 8'h14;
  // Error locations, two BCD digits
  localparam logic [7:0] LOC_WATCHDOG = 8'h01;
  localparam logic [7:0] LOC_CFG_MEM  = 8'h02;
  localparam logic [7:0] LOC_RAM      = 8'h03;
  localparam logic [7:0] LOC_CONFIG   = 8'h04;
  localparam logic [7:0] LOC_SM2_DATA = 8'h05;
  localparam logic [7:0] LOC_LOCAL    = 8'h06;
  // Number of fault sources
  localparam int unsigned N_FAULT     = 6;

  // Drive states held while the power stage is not released
  localparam logic [2:0] DRV_NOT_READY    = 3'h1;
  localparam logic [2:0] DRV_ON_DISABLED  = 3'h2;

  // Display phases of the fault sequence
  typedef enum logic [1:0] {
    FSI_PH_ER  = 2'h0,
    FSI_PH_GRP = 2'h1,
    FSI_PH_LOC = 2'h2,
    FSI_PH_GAP = 2'h3
  } fsi_phase_t;

endpackage

// File: design/fsi_sync.sv
/*
  Three-flip-flop synchroniser for one pin input with agreement filter.
  Assumes the pin is asynchronous to mclk_i.
*/
`timescale 1ns/1ns
module fsi_sync (
  input  wire logic mclk_i,   // System clock
  input  wire logic rst_n_i,  // Async reset, active low
  input  wire logic pin_i,    // Raw pin level
  output logic      level_o   // Filtered level
);

  logic s1;  // First stage, read only by s2
  logic s2;  // Second stage
  logic s3;  // Third stage

  // Shift chain
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end

endmodule // fsi_sync

// File: test/fsi_master_model.sv
/*
  Behavioural model of the party across one network socket: it drives that
  socket's PHY link and traffic pins.
  Assumes the bench commands it with levels that change on mclk_i.
*/
`timescale 1ns/1ns
module fsi_master_model (
  input  wire logic mclk_i,     // System clock
  input  wire logic link_up_i,  // Cable plugged and partner powered
  input  wire logic traffic_i,  // Frames are being exchanged
  output logic      link_o,     // PHY link pin
  output logic      act_o       // Traffic pin
);
  // Pins move only on the clock; there is no traffic without a link
  always_ff @(posedge mclk_i) begin
    link_o <= link_up_i;
    act_o  <= link_up_i & traffic_i;
  end
endmodule // fsi_master_model

// File: test/testbench.sv
/*
  Self-checking bench for the fieldbus status indicator.
  Assumes a blink half period of 4 cycles, shortened to 2 in one scenario.
*/
`timescale 1ns/1ns
module testbench;
  import fsi_pkg::*;
  logic mclk_i = 1'b0;                  // System clock
  logic rst_n_i = 1'b0;                 // Reset, active low
  logic cmp = 1'b0;                     // Compact strap
  logic [PRE_W-1:0] pre = 24'h000004;   // Blink half period in cycles
  logic [1:0] st = 2'h0;                // Slave state
  logic [N_FAULT-1:0] flt = '0;         // Fault pulses
  logic ack = 1'b0;                     // Fault clear
  logic ena = 1'b0;                     // Hardware enable pin
  logic tor = 1'b0;                     // Torque-off release pin
  logic il = 1'b0, it = 1'b0;           // Input socket commands
  logic ol = 1'b0, ot = 1'b0;           // Output socket commands
  logic in_link, in_act, out_link, out_act; // Pins from the models
  logic in_la, out_la, in_phy, out_phy, run, ring, rel, fact; // LEDs, flags
  logic [7:0] disp;                     // Display code
  int num_errors = 0;                   // Mismatches
  int n_checks = 0;                     // Comparisons
  int k;                                // Scratch count
  logic [N_FAULT-1:0] fm[7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h30};
  logic [7:0] fl[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h05};
  logic [3:0] rk[4] = '{4'h0, 4'h1, 4'h2, 4'h3}; // enable pin pairs
  int rc[4] = '{0, 24, 8, 48};          // Lit cycles in 48 per state

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  // Master at the start of the line feeds the input socket
  fsi_master_model master (.mclk_i(mclk_i), .link_up_i(il), .traffic_i(it),
    .link_o(in_link), .act_o(in_act));
  // Next slave on the output socket
  fsi_master_model next_slave (.mclk_i(mclk_i), .link_up_i(ol), .traffic_i(ot),
    .link_o(out_link), .act_o(out_act));

  fsi_indicator dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .compact_variant_i(cmp),
    .prescale_i(pre), .in_link_i(in_link), .in_act_i(in_act),
    .out_link_i(out_link), .out_act_i(out_act), .slave_state_i(st), .fault_i(flt),
    .fault_ack_i(ack), .power_stage_hw_enable_i(ena), .torque_off_release_input_i(tor),
    .in_la_led_o(in_la), .out_la_led_o(out_la), .in_phy_led_o(in_phy),
    .out_phy_led_o(out_phy), .run_state_indicator_o(run), .ring_loop_o(ring),
    .power_release_o(rel), .fault_active_o(fact), .disp_o(disp));

  // Prints the verdict and stops
  task automatic report_and_stop;
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compares one value
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits n edges, then steps off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #10;
  endtask

  // Counts cycles in 48 where the chosen output is lit, or run LED changes
  task automatic lit48(input int sel, output int cnt);
    logic prev;                         // Run LED one sample back
    cnt = 0;
    prev = run;
    repeat (48) begin
      cyc(1);
      case (sel)
        0: cnt += (run === 1'b1);
        1: cnt += (in_la === 1'b1);
        3: cnt += (run !== prev);
        default: cnt += (out_la === 1'b1);
      endcase
      prev = run;
    end
  endtask

  // Waits for a display code, bounded
  task automatic wait_disp(input logic [7:0] v, input int lim);
    int i;
    for (i = 0; i < lim && disp !== v; i++) cyc(1);
    check("display", disp, v);
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    report_and_stop();
  end

  initial begin
    cyc(10);
    rst_n_i = 1'b1;
    cyc(8);
    check("ring idle", {7'h0, ring}, 8'h01);
    check("release idle", {7'h0, rel}, 8'h00);
    // Link, then traffic, on both sockets
    lit48(1, k);
    check("la nolink", k[7:0], 8'h00);
    il = 1'b1;
    ol = 1'b1;
    cmp = 1'b1;
    cyc(8);
    lit48(1, k);
    check("la link", k[7:0], 8'h30);
    check("phy in", {7'h0, in_phy}, 8'h01);
    check("ring closed", {7'h0, ring}, 8'h00);
    it = 1'b1;
    ot = 1'b1;
    cyc(8);
    lit48(2, k);
    check("la traffic", k[7:0], 8'h18);
    check("phy traffic", {7'h0, out_phy}, 8'h01);
    il = 1'b0;
    cmp = 1'b0;
    cyc(8);
    check("phy nolink", {7'h0, in_phy}, 8'h00);
    check("phy std", {7'h0, out_phy}, 8'h00);
    // Run LED per slave state
    for (int s = 0; s < 4; s++) begin
      st = s[1:0];
      cyc(2);
      lit48(0, k);
      check("run lit", k[7:0], rc[s][7:0]);
    end
    // Blink rate follows the programmed half period
    st = 2'h1;
    cyc(2);
    lit48(3, k);
    check("blink toggles 4", k[7:0], 8'h0c);
    pre = 24'h000002;
    cyc(4);
    lit48(3, k);
    check("blink toggles 2", k[7:0], 8'h18);
    pre = 24'h000004;
    // Fault codes, one after another, then two at once
    for (int f = 0; f < 7; f++) begin
      flt = fm[f];
      cyc(1);
      flt = '0;
      cyc(1);
      check("fault flag", {7'h0, fact}, 8'h01);
      wait_disp(8'hee, 4);
      wait_disp(ERR_GROUP, 20);
      wait_disp(fl[f], 20);
      ack = 1'b1;
      cyc(1);
      ack = 1'b0;
      cyc(2);
      check("fault clear", {7'h0, fact}, 8'h00);
    end
    // Reset in mid-run drops a shown fault and reopens the ring
    flt = 6'h04;
    cyc(1);
    flt = '0;
    rst_n_i = 1'b0;
    cyc(1);
    check("reset flag", {7'h0, fact}, 8'h00);
    check("reset disp", disp, 8'hff);
    check("reset ring", {7'h0, ring}, 8'h01);
    rst_n_i = 1'b1;
    cyc(2);
    check("after reset flag", {7'h0, fact}, 8'h00);
    check("after reset disp", disp, 8'hff);
    // Power release needs both pins
    for (int e = 0; e < 4; e++) begin
      {ena, tor} = rk[e][1:0];
      cyc(8);
      check("release", {7'h0, rel}, {7'h0, ena & tor});
    end
    ena = 1'b0;
    cyc(8);
    check("release drop", {7'h0, rel}, 8'h00);
    ol = 1'b0;
    cyc(8);
    check("ring open", {7'h0, ring}, 8'h01);
    report_and_stop();
  end
endmodule // testbench
